/* core/aph_pkg.sv */
// shared constants and types for the adc parallel host port
package aph_pkg;
  localparam int RES_W = 12;
  localparam int BUS_W = 8;
  localparam int CFG_W = 8;
  // configuration bit that selects acquisition mode (0: internal, 1: external)
  localparam int CFG_ACQ_BIT = 5;
  // conversion clock cycles per conversion
  localparam int CONV_CYCLES = 13;
  // internal acquisition length in conversion clock cycles
  localparam int ACQ_CYCLES = 3;
  // internal conversion clock divider (half period in sys_clk cycles)
  localparam int INT_CLK_HALF = 10;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [RES_W-1:0] RES_RST = 12'h000;
  localparam logic [CFG_W-1:0] CFG_RST = 8'h00;
  // host strobe timing in sys_clk cycles
  localparam int STROBE_CYCLES = 4;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACQ = 2'b01,
    ST_CONV = 2'b10,
    ST_DONE = 2'b11
  } aph_dev_state_t;
  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_WR = 3'b001,
    HS_WAIT = 3'b010,
    HS_RD = 3'b011,
    HS_GAP = 3'b100
  } aph_host_state_t;
endpackage : aph_pkg

/* core/aph_if.sv */
// pin-level link between adc parallel port and its host
`timescale 1ns/1ps
`default_nettype none
interface aph_if;
  import aph_pkg::*;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic byte_select_high;
  logic conv_clk;
  logic [BUS_W-1:0] host_d_out;
  logic host_d_oe;
  logic [BUS_W-1:0] dev_d_out;
  logic dev_d_oe;
  logic done_n_out;
  logic done_n_oe;
  logic [BUS_W-1:0] d_bus;
  logic done_n;
  // wire resolution; floating lines read as pulled high
  assign d_bus = dev_d_oe ? dev_d_out : (host_d_oe ? host_d_out : {BUS_W{1'b1}});
  assign done_n = done_n_oe ? done_n_out : 1'b1;
  modport dev (
    input cs_n, rd_n, wr_n, byte_select_high, conv_clk, d_bus,
    output dev_d_out, dev_d_oe, done_n_out, done_n_oe
  );
  modport host (
    output cs_n, rd_n, wr_n, byte_select_high, conv_clk, host_d_out, host_d_oe,
    input d_bus, done_n
  );
endinterface : aph_if
`default_nettype wire

/* core/aph_device.sv */
// adc end of the parallel host port: strobes, conversion sequencing, byte mux
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module aph_device #(
  parameter int CONV_N = aph_pkg::CONV_CYCLES,
  parameter int ACQ_N = aph_pkg::ACQ_CYCLES
) (
  input wire logic sys_clk,
  input wire logic srst,
  aph_if.dev link,
  input wire logic ext_clk_mode,
  input wire logic [aph_pkg::RES_W-1:0] analog_sample,
  output logic [aph_pkg::RES_W-1:0] result,
  output logic [aph_pkg::CFG_W-1:0] config_byte,
  output logic busy
);
  import aph_pkg::*;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [4:0] s1_reg, s1_next, s2_reg, s2_next, s3_reg, s3_next;
  logic [BUS_W-1:0] d1_reg, d2_reg;
  always_comb begin
    s1_next = {link.cs_n, link.rd_n, link.wr_n, link.byte_select_high, link.conv_clk};
    s2_next = s1_reg;
    s3_next = s2_reg;
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      // idle pin levels (select and clock low) so no false edge follows reset
      s1_reg <= 5'h1c;
      s2_reg <= 5'h1c;
      s3_reg <= 5'h1c;
      d1_reg <= '0;
      d2_reg <= '0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      d1_reg <= link.d_bus;
      d2_reg <= d1_reg;
    end
  end
  logic cs_n_s, rd_n_s, wr_n_s, hsel_s, clk_s, clk_p;
  logic wr_rise, rd_fall;
  assign cs_n_s = s2_reg[4];
  assign rd_n_s = s2_reg[3];
  assign wr_n_s = s2_reg[2];
  assign hsel_s = s2_reg[1];
  assign clk_s = s2_reg[0];
  assign clk_p = s3_reg[0];
  assign wr_rise = wr_n_s && !s3_reg[2] && !cs_n_s;
  assign rd_fall = !rd_n_s && s3_reg[3] && !cs_n_s;

  // ------------------------------------------------------------
  // conversion clock ticks: external pin edges or internal divider
  // ------------------------------------------------------------
  logic [CNT_W-1:0] div_reg, div_next;
  logic iclk_reg, iclk_next;
  logic tick;
  always_comb begin
    div_next = div_reg + 8'h01;
    iclk_next = iclk_reg;
    if (div_reg == CNT_W'(INT_CLK_HALF - 1)) begin
      div_next = CNT_ZERO;
      iclk_next = !iclk_reg;
    end
    // one tick per falling edge of the conversion clock
    if (ext_clk_mode)
      tick = clk_p && !clk_s;
    else
      tick = iclk_reg && (div_reg == CNT_W'(INT_CLK_HALF - 1));
  end

  // ------------------------------------------------------------
  // sequencer: acquisition, successive approximation, done
  // ------------------------------------------------------------
  aph_dev_state_t st_reg, st_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [CFG_W-1:0] cfg_reg, cfg_next;
  logic [RES_W-1:0] sar_reg, sar_next, res_reg, res_next, bit_reg, bit_next;
  logic done_reg, done_next;
  logic ext_acq;
  assign ext_acq = cfg_reg[CFG_ACQ_BIT];
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    cfg_next = cfg_reg;
    sar_next = sar_reg;
    res_next = res_reg;
    bit_next = bit_reg;
    done_next = done_reg;
    if (rd_fall)
      done_next = 1'b0;
    case (st_reg)
      ST_IDLE, ST_DONE: begin
        if (wr_rise) begin
          cfg_next = d2_reg;
          done_next = 1'b0;
          cnt_next = CNT_ZERO;
          if (d2_reg[CFG_ACQ_BIT]) begin
            st_next = ST_ACQ; // external acquisition: wait for next write rise
          end else begin
            st_next = ST_ACQ;
          end
        end
      end
      ST_ACQ: begin
        // external mode ends on the first write rise; internal on a tick count
        if (ext_acq ? wr_rise : (tick && cnt_reg == CNT_W'(ACQ_N - 1))) begin
          st_next = ST_CONV;
          cnt_next = CNT_ZERO;
          sar_next = RES_RST;
          bit_next = {1'b1, {(RES_W-1){1'b0}}};
        end else if (!ext_acq && tick) begin
          cnt_next = cnt_reg + 8'h01;
        end
      end
      ST_CONV: begin
        if (tick) begin
          cnt_next = cnt_reg + 8'h01;
          // one trial bit per tick, msb first, until the mask runs out
          if (bit_reg != RES_RST) begin
            if ((sar_reg | bit_reg) <= analog_sample)
              sar_next = sar_reg | bit_reg;
            bit_next = bit_reg >> 1;
          end
          if (cnt_reg == CNT_W'(CONV_N - 1)) begin
            st_next = ST_DONE;
            res_next = sar_next;
            done_next = 1'b1;
          end
        end
      end
      default: st_next = ST_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      div_reg <= CNT_ZERO;
      iclk_reg <= 1'b0;
      st_reg <= ST_IDLE;
      cnt_reg <= CNT_ZERO;
      cfg_reg <= CFG_RST;
      sar_reg <= RES_RST;
      res_reg <= RES_RST;
      bit_reg <= RES_RST;
      done_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      iclk_reg <= iclk_next;
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      cfg_reg <= cfg_next;
      sar_reg <= sar_next;
      res_reg <= res_next;
      bit_reg <= bit_next;
      done_reg <= done_next;
    end
  end

  // ------------------------------------------------------------
  // pin drivers
  // ------------------------------------------------------------
  logic [BUS_W-1:0] dout_reg, dout_next;
  logic doe_reg, doe_next, int_oe_reg, int_oe_next, int_n_reg, int_n_next;
  always_comb begin
    // level-driven so cs falling inside a read and select changes act at once
    doe_next = !cs_n_s && !rd_n_s && wr_n_s;
    if (hsel_s)
      dout_next = {4'h0, res_reg[RES_W-1:8]};
    else
      dout_next = res_reg[7:0];
    int_oe_next = !cs_n_s;
    int_n_next = !done_reg;
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dout_reg <= 8'h00;
      doe_reg <= 1'b0;
      int_oe_reg <= 1'b0;
      int_n_reg <= 1'b1;
    end else begin
      dout_reg <= dout_next;
      doe_reg <= doe_next;
      int_oe_reg <= int_oe_next;
      int_n_reg <= int_n_next;
    end
  end
  assign link.dev_d_out = dout_reg;
  assign link.dev_d_oe = doe_reg;
  assign link.done_n_out = int_n_reg;
  assign link.done_n_oe = int_oe_reg;

  logic busy_reg;
  always_ff @(posedge sys_clk) begin
    if (srst)
      busy_reg <= 1'b0;
    else
      busy_reg <= (st_next == ST_ACQ) || (st_next == ST_CONV);
  end
  assign result = res_reg;
  assign config_byte = cfg_reg;
  assign busy = busy_reg;
endmodule : aph_device
`default_nettype wire

/* core/aph_host.sv */
// microprocessor end: writes a config byte, waits for done, reads both bytes
`timescale 1ns/1ps
`default_nettype none
module aph_host #(
  parameter int STROBE_N = aph_pkg::STROBE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic srst,
  aph_if.host link,
  input wire logic start,
  input wire logic [aph_pkg::CFG_W-1:0] cfg_in,
  input wire logic ext_clk_mode,
  output logic [aph_pkg::RES_W-1:0] rd_data,
  output logic rd_valid,
  output logic idle
);
  import aph_pkg::*;

  // ------------------------------------------------------------
  // done and data bus synchroniser
  // ------------------------------------------------------------
  logic dn1_reg, dn2_reg;
  logic [BUS_W-1:0] db1_reg, db2_reg;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dn1_reg <= 1'b1;
      dn2_reg <= 1'b1;
      db1_reg <= 8'h00;
      db2_reg <= 8'h00;
    end else begin
      dn1_reg <= link.done_n;
      dn2_reg <= dn1_reg;
      db1_reg <= link.d_bus;
      db2_reg <= db1_reg;
    end
  end

  // ------------------------------------------------------------
  // bus sequencer
  // ------------------------------------------------------------
  aph_host_state_t st_reg, st_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next, clk_div_reg, clk_div_next;
  logic cs_n_reg, cs_n_next, rd_n_reg, rd_n_next, wr_n_reg, wr_n_next;
  logic hsel_reg, hsel_next, oe_reg, oe_next, valid_reg, valid_next, cclk_reg, cclk_next;
  logic [BUS_W-1:0] dout_reg, dout_next;
  logic [RES_W-1:0] data_reg, data_next;
  logic again_reg, again_next;
  logic last;
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg + 8'h01;
    cs_n_next = cs_n_reg;
    rd_n_next = rd_n_reg;
    wr_n_next = wr_n_reg;
    hsel_next = hsel_reg;
    oe_next = oe_reg;
    dout_next = dout_reg;
    data_next = data_reg;
    valid_next = 1'b0;
    again_next = again_reg;
    last = (cnt_reg == CNT_W'(STROBE_N - 1));
    // continuous clock in external mode, static low otherwise
    clk_div_next = clk_div_reg + 8'h01;
    cclk_next = cclk_reg;
    if (clk_div_reg == CNT_W'(INT_CLK_HALF - 1)) begin
      clk_div_next = CNT_ZERO;
      cclk_next = ext_clk_mode ? !cclk_reg : 1'b0;
    end
    case (st_reg)
      HS_IDLE: begin
        cnt_next = CNT_ZERO;
        if (start) begin
          st_next = HS_WR;
          cs_n_next = 1'b0;
          wr_n_next = 1'b0;
          oe_next = 1'b1;
          dout_next = cfg_in;
          again_next = cfg_in[CFG_ACQ_BIT];
        end
      end
      HS_WR: begin
        if (last) begin
          wr_n_next = 1'b1;
          cnt_next = CNT_ZERO;
          st_next = HS_GAP;
        end
      end
      HS_GAP: begin
        // hold data past the rising edge, then release; write stays high
        // external acquisition: a second write pulse ends acquisition
        // chip select stays low, since done floats while deselected
        if (again_reg && cnt_reg == CNT_W'(2 * STROBE_N - 1)) begin
          again_next = 1'b0;
          wr_n_next = 1'b0;
          cnt_next = CNT_ZERO;
          st_next = HS_WR;
        end else if (!again_reg && last) begin
          oe_next = 1'b0;
          st_next = HS_WAIT;
        end
      end
      HS_WAIT: begin
        cnt_next = CNT_ZERO;
        if (!dn2_reg) begin
          cs_n_next = 1'b0;
          rd_n_next = 1'b0;
          hsel_next = 1'b0;
          st_next = HS_RD;
        end
      end
      HS_RD: begin
        // one read strobe; switch to the high byte halfway through
        if (cnt_reg == CNT_W'(2 * STROBE_N - 1)) begin
          data_next[7:0] = data_reg[7:0];
          hsel_next = 1'b1;
        end
        if (cnt_reg == CNT_W'(STROBE_N + 1))
          data_next[7:0] = db2_reg;
        if (cnt_reg == CNT_W'(2 * STROBE_N - 1))
          hsel_next = 1'b1;
        if (cnt_reg == CNT_W'(4 * STROBE_N - 1)) begin
          data_next[RES_W-1:8] = db2_reg[3:0];
          rd_n_next = 1'b1;
          cs_n_next = 1'b1;
          valid_next = 1'b1;
          st_next = HS_IDLE;
        end
      end
      default: st_next = HS_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_reg <= HS_IDLE;
      cnt_reg <= CNT_ZERO;
      clk_div_reg <= CNT_ZERO;
      cclk_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      hsel_reg <= 1'b0;
      oe_reg <= 1'b0;
      dout_reg <= 8'h00;
      data_reg <= RES_RST;
      valid_reg <= 1'b0;
      again_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      clk_div_reg <= clk_div_next;
      cclk_reg <= cclk_next;
      cs_n_reg <= cs_n_next;
      rd_n_reg <= rd_n_next;
      wr_n_reg <= wr_n_next;
      hsel_reg <= hsel_next;
      oe_reg <= oe_next;
      dout_reg <= dout_next;
      data_reg <= data_next;
      valid_reg <= valid_next;
      again_reg <= again_next;
    end
  end
  assign link.cs_n = cs_n_reg;
  assign link.rd_n = rd_n_reg;
  assign link.wr_n = wr_n_reg;
  assign link.byte_select_high = hsel_reg;
  assign link.conv_clk = cclk_reg;
  assign link.host_d_out = dout_reg;
  assign link.host_d_oe = oe_reg;
  assign rd_data = data_reg;
  assign rd_valid = valid_reg;
  logic idle_reg;
  always_ff @(posedge sys_clk) begin
    if (srst)
      idle_reg <= 1'b1;
    else
      idle_reg <= (st_next == HS_IDLE);
  end
  assign idle = idle_reg;
endmodule : aph_host
`default_nettype wire

/* sim/aph_sva.sv */
// checks on the wires between the adc port and its host
`timescale 1ns/1ps
`default_nettype none
module aph_sva #(
  parameter int CONV_N = aph_pkg::CONV_CYCLES
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic byte_select_high,
  input wire logic conv_clk,
  input wire logic [aph_pkg::BUS_W-1:0] dev_d_out,
  input wire logic dev_d_oe,
  input wire logic done_n_out,
  input wire logic done_n_oe
);
  import aph_pkg::*;
  // first tick may follow conversion start at once, so only CONV_N-1 full periods
  localparam int MIN_CYC = (CONV_N - 1) * 2 * INT_CLK_HALF;
  // ------------------------------
  // time since a write was taken
  // ------------------------------
  logic [15:0] cyc_reg, cyc_next;
  logic [7:0] fall_reg, fall_next;
  logic wr_d_reg, wr_d_next, clk_d_reg, clk_d_next;
  always_comb begin
    wr_d_next = wr_n;
    clk_d_next = conv_clk;
    cyc_next = (cyc_reg == 16'hffff) ? cyc_reg : cyc_reg + 16'h0001;
    fall_next = fall_reg;
    if (clk_d_reg && !conv_clk && fall_reg != 8'hff) begin
      fall_next = fall_reg + 8'h01;
    end
    // both measures restart, as the clock source is not visible here
    if (wr_n && !wr_d_reg && !cs_n) begin
      cyc_next = 16'h0000;
      fall_next = 8'h00;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cyc_reg <= 16'h0000;
      fall_reg <= 8'h00;
      wr_d_reg <= 1'b1;
      clk_d_reg <= 1'b0;
    end else begin
      cyc_reg <= cyc_next;
      fall_reg <= fall_next;
      wr_d_reg <= wr_d_next;
      clk_d_reg <= clk_d_next;
    end
  end
  // ------------------------------
  // properties
  // ------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence s_read_held;
    (!cs_n && !rd_n) [*4];
  endsequence
  sequence s_read_gone;
    (cs_n || rd_n) [*4];
  endsequence
  sequence s_high_held;
    (dev_d_oe && byte_select_high) [*5];
  endsequence
  a_read_drives: assert property (s_read_held |-> dev_d_oe)
    else $error("bus not driven in read");
  a_oe_cause: assert property (dev_d_oe |-> !$past(cs_n, 3) && !$past(rd_n, 3))
    else $error("bus driven without read");
  a_no_write_drive: assert property (!wr_n |-> !dev_d_oe)
    else $error("bus driven during write");
  a_read_release: assert property (s_read_gone |-> !dev_d_oe)
    else $error("bus not released");
  a_float_idle: assert property (cs_n [*4] |-> !done_n_oe)
    else $error("done driven while deselected");
  a_high_nibble: assert property (s_high_held |-> dev_d_out[7:4] == 4'h0)
    else $error("high byte upper lines not zero");
  a_done_clear: assert property (!cs_n && $fell(rd_n) |-> ##[1:5] done_n_out)
    else $error("done not cleared by read");
  a_read_after_done: assert property (!cs_n && $fell(rd_n) |-> !done_n_out)
    else $error("read before done");
  a_conv_length: assert property ($fell(done_n_out) |->
    cyc_reg >= MIN_CYC || fall_reg >= CONV_N)
    else $error("conversion too short");
  a_write_hold: assert property ($rose(wr_n) && !cs_n |-> wr_n [*8])
    else $error("write strobe lowered too soon");
endmodule : aph_sva
`default_nettype wire

/* sim/testbench.sv */
// bench joining both port ends: random conversions checked end to end
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import aph_pkg::*;
  localparam int N_RUNS = 16;
  localparam int WAIT_MAX = 4000;
  localparam int CYC_MAX = 80000;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic start = 1'b0;
  logic ext_mode = 1'b0;
  logic [CFG_W-1:0] cfg = CFG_RST;
  logic [RES_W-1:0] sample = RES_RST;
  logic [RES_W-1:0] result;
  logic [RES_W-1:0] rd_data;
  logic [CFG_W-1:0] config_byte;
  logic busy;
  logic rd_valid;
  logic idle;
  logic [4:0] sel_q = 5'h00;
  logic [4:0] cs_q = 5'h1f;
  int n_fail = 0;
  int n_compared = 0;
  int seed = 71904;
  int cyc = 0;
  aph_if link_if();
  aph_device i_aph_device (.sys_clk(sys_clk), .srst(srst), .link(link_if.dev),
    .ext_clk_mode(ext_mode), .analog_sample(sample), .result(result),
    .config_byte(config_byte), .busy(busy));
  aph_host i_aph_host (.sys_clk(sys_clk), .srst(srst), .link(link_if.host), .start(start),
    .cfg_in(cfg), .ext_clk_mode(ext_mode), .rd_data(rd_data), .rd_valid(rd_valid),
    .idle(idle));
  aph_sva i_aph_sva (.sys_clk(sys_clk), .srst(srst), .cs_n(link_if.cs_n),
    .rd_n(link_if.rd_n), .wr_n(link_if.wr_n), .byte_select_high(link_if.byte_select_high),
    .conv_clk(link_if.conv_clk), .dev_d_out(link_if.dev_d_out), .dev_d_oe(link_if.dev_d_oe),
    .done_n_out(link_if.done_n_out), .done_n_oe(link_if.done_n_oe));
  always #5 sys_clk = ~sys_clk;
  // ------------------------------
  // compare and verdict
  // ------------------------------
  task automatic print_verdict();
    if (n_fail == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict
  task automatic check12(input string what, input logic [RES_W-1:0] exp,
    input logic [RES_W-1:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check12
  task automatic check8(input string what, input logic [BUS_W-1:0] exp,
    input logic [BUS_W-1:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check8
  function automatic logic [BUS_W-1:0] exp_byte(input logic [RES_W-1:0] s, input logic hi);
    return hi ? {4'h0, s[11:8]} : s[7:0];
  endfunction : exp_byte
  // ------------------------------
  // wire watch and hang guard
  // ------------------------------
  always @(posedge sys_clk) begin
    sel_q <= {sel_q[3:0], link_if.byte_select_high};
    cs_q <= {cs_q[3:0], link_if.cs_n};
    cyc <= cyc + 1;
    if (cyc >= CYC_MAX) begin
      n_fail++;
      print_verdict();
    end
  end
  // select held five samples, so the three-cycle lag has settled
  always @(negedge sys_clk) begin
    if (!srst && link_if.dev_d_oe && (sel_q == 5'h1f || sel_q == 5'h00)) begin
      check8("data bus", exp_byte(sample, sel_q[0]), link_if.d_bus);
    end
    if (!srst && cs_q == 5'h1f) begin
      check8("enables", 8'h00, {6'h00, link_if.done_n_oe, link_if.dev_d_oe});
    end
  end
  // ------------------------------
  // one conversion and read-back
  // ------------------------------
  task automatic run_one(input int i);
    int k;
    k = 0;
    while (idle !== 1'b1 && k < WAIT_MAX) begin
      @(negedge sys_clk);
      k++;
    end
    check8("idle wait", 8'h01, {7'h00, idle});
    // the bus stays driven a few cycles after the host goes idle
    repeat (4) @(negedge sys_clk);
    if (i == 8) begin
      srst = 1'b1;
      repeat (2) @(negedge sys_clk);
      srst = 1'b0;
      check12("result after reset", RES_RST, result);
    end
    case (i)
      0: sample = 12'h000;
      1: sample = 12'hfff;
      2: sample = 12'ha5a;
      3: sample = 12'h5a5;
      default: sample = 12'($random(seed));
    endcase
    ext_mode = (i < 4) ? i[0] : 1'($random(seed));
    cfg = (i < 4) ? {2'b00, i[1], 5'h0c} : 8'($random(seed));
    start = 1'b1;
    @(negedge sys_clk);
    start = 1'b0;
    repeat (12) @(negedge sys_clk);
    check8("busy", 8'h01, {7'h00, busy});
    k = 0;
    while (rd_valid !== 1'b1 && k < WAIT_MAX) begin
      @(negedge sys_clk);
      k++;
    end
    check8("read valid", 8'h01, {7'h00, rd_valid});
    check12("read result", sample, rd_data);
    check8("busy after read", 8'h00, {7'h00, busy});
    check12("device result", sample, result);
    check8("config byte", cfg, config_byte);
  endtask : run_one
  initial begin
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    srst = 1'b0;
    for (int i = 0; i < N_RUNS; i++) begin
      run_one(i);
    end
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
